// file: cfer_event_req.sv
// module: codec fifo event, dma request and interrupt pending logic
//
// Summary of operation
// - trigger control register, sixteen bits, read/write, zero after reset
// - bits 3:0 give first capture fifo trigger level in empty words
// - bits 7:4 give second capture fifo trigger level in empty words
// - bits 11:8 give playback trigger level in valid words, either fifo
// - bit 12 requests dma on first capture trigger unless its interrupt enabled
// - bit 13 requests dma on second capture trigger unless its interrupt enabled
// - bit 14 requests dma on left playback trigger unless its interrupt enabled
// - bit 15 requests dma on right playback trigger unless its interrupt enabled
// - interrupt enable register, zero after reset; pending updates only when any enabled
// - enable bit 0: first capture trigger, full or empty interrupts
// - enable bit 1: second capture trigger, full or empty interrupts
// - enable bit 2: left playback trigger, full or empty interrupts
// - enable bit 3: right playback trigger, full or empty interrupts
// - enable bits 4 to 6: converter power-up complete interrupts
// - enable bits 7 to 9: converter power-down complete interrupts
// - enable bit 10: left filter output sign change interrupt
// - outer coefficients register, zero after reset, used only with custom compensation
// - inner coefficients register, zero after reset, used only with custom compensation
// - pending bit set only when source enabled and asserting, same positions
// - writing one clears a pending bit while any enable is set, zero leaves it alone
// - enable bit 11: right filter output zero crossing interrupt
// - enable bits 12 and 13: microphone clip and sidetone clip interrupts
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
module cfer_event_req import cfer_pkg::*; #(
	parameter int CNT_W = 5
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// axi4-lite write address and data
	input wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [AXI_DATA_W-1:0] S_AXI_WDATA,
	input wire logic [AXI_STRB_W-1:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// axi4-lite write response
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// axi4-lite read
	input wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [AXI_DATA_W-1:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// capture fifo status
	input wire logic [CNT_W-1:0] CAP1_EMPTY_WORDS,
	input wire logic CAP1_FULL,
	input wire logic CAP1_EMPTY,
	input wire logic [CNT_W-1:0] CAP2_EMPTY_WORDS,
	input wire logic CAP2_FULL,
	input wire logic CAP2_EMPTY,
	// playback fifo status
	input wire logic [CNT_W-1:0] PLAY_L_VALID_WORDS,
	input wire logic PLAY_L_FULL,
	input wire logic PLAY_L_EMPTY,
	input wire logic [CNT_W-1:0] PLAY_R_VALID_WORDS,
	input wire logic PLAY_R_FULL,
	input wire logic PLAY_R_EMPTY,
	// converter and filter events
	input wire logic [NUM_CONV-1:0] POWERUP_DONE,
	input wire logic [NUM_CONV-1:0] POWERDOWN_DONE,
	input wire logic LEFT_FILTER_SIGN,
	input wire logic RIGHT_FILTER_SIGN,
	input wire logic MIC_CLIP,
	input wire logic SIDETONE_CLIP_L,
	input wire logic SIDETONE_CLIP_R,
	// requests
	output logic [NUM_FIFO-1:0] DMA_REQ,
	output logic CODEC_IRQ,
	// compensation filter coefficients
	output logic CUSTOM_COMP,
	output logic [REG_W-1:0] COEFF_OUTER,
	output logic [REG_W-1:0] COEFF_INNER
);
	cfer_reg_if rb ();
	logic [REG_W-1:0] trig_r;
	logic [REG_W-1:0] irqen_r;
	logic [REG_W-1:0] pend_r;
	logic [REG_W-1:0] pend_nxt;
	logic [REG_W-1:0] cout_r;
	logic [REG_W-1:0] cin_r;
	logic [REG_W-1:0] filt_r;
	logic [REG_W-1:0] pend_clr;
	logic [REG_W-1:0] src;
	logic [CNT_W-1:0] fifo_cnt [NUM_FIFO];
	logic [TRIG_LVL_W-1:0] fifo_lvl [NUM_FIFO];
	logic [NUM_FIFO-1:0] fifo_full;
	logic [NUM_FIFO-1:0] fifo_empty;
	logic [NUM_FIFO-1:0] trig_hit;
	logic [NUM_FIFO-1:0] dma_nxt;
	logic sign_l_r;
	logic sign_r_r;
	cfer_sel_e wr_sel;

	// merges a write into a 16-bit register through the low byte lanes
	function automatic logic [REG_W-1:0] cfer_merge(input logic [REG_W-1:0] old,
		input logic [AXI_DATA_W-1:0] data, input logic [AXI_STRB_W-1:0] strb);
		cfer_merge = old;
		if (strb[0]) begin
			cfer_merge[7:0] = data[7:0];
		end
		if (strb[1]) begin
			cfer_merge[15:8] = data[15:8];
		end
	endfunction : cfer_merge

	// bus front end
	cfer_axil_slave u_slave (
		.clk(SYS_CLK),
		.rst(RST),
		.awaddr(S_AXI_AWADDR),
		.awvalid(S_AXI_AWVALID),
		.awready(S_AXI_AWREADY),
		.wdata(S_AXI_WDATA),
		.wstrb(S_AXI_WSTRB),
		.wvalid(S_AXI_WVALID),
		.wready(S_AXI_WREADY),
		.bresp(S_AXI_BRESP),
		.bvalid(S_AXI_BVALID),
		.bready(S_AXI_BREADY),
		.araddr(S_AXI_ARADDR),
		.arvalid(S_AXI_ARVALID),
		.arready(S_AXI_ARREADY),
		.rdata(S_AXI_RDATA),
		.rresp(S_AXI_RRESP),
		.rvalid(S_AXI_RVALID),
		.rready(S_AXI_RREADY),
		.rb(rb.master)
	);

	assign wr_sel = rb.wr_stb ? cfer_decode(rb.wr_addr) : SEL_NONE;

	// fifo status gathered per channel, capture counts empty, playback counts valid
	assign fifo_cnt[0] = CAP1_EMPTY_WORDS;
	assign fifo_cnt[1] = CAP2_EMPTY_WORDS;
	assign fifo_cnt[2] = PLAY_L_VALID_WORDS;
	assign fifo_cnt[3] = PLAY_R_VALID_WORDS;
	assign fifo_lvl[0] = trig_r[TRIG_CAP1_LSB +: TRIG_LVL_W];
	assign fifo_lvl[1] = trig_r[TRIG_CAP2_LSB +: TRIG_LVL_W];
	assign fifo_lvl[2] = trig_r[TRIG_PLAY_LSB +: TRIG_LVL_W];
	assign fifo_lvl[3] = trig_r[TRIG_PLAY_LSB +: TRIG_LVL_W];
	assign fifo_full = {PLAY_R_FULL, PLAY_L_FULL, CAP2_FULL, CAP1_FULL};
	assign fifo_empty = {PLAY_R_EMPTY, PLAY_L_EMPTY, CAP2_EMPTY, CAP1_EMPTY};

	// per-fifo trigger, interrupt source and dma steering
	for (genvar i = 0; i < NUM_FIFO; i++) begin : g_fifo
		assign trig_hit[i] = (fifo_cnt[i] <= CNT_W'(fifo_lvl[i]));
		assign src[IRQ_FIFO_LSB + i] = trig_hit[i] | fifo_full[i] | fifo_empty[i];
		assign dma_nxt[i] = trig_r[TRIG_DMA_LSB + i] & ~irqen_r[IRQ_FIFO_LSB + i] & trig_hit[i];

		// interrupt enable wins over the dma enable
		dma_excl_a: assert property (@(posedge SYS_CLK) disable iff (RST)
			irqen_r[IRQ_FIFO_LSB + i] |=> !DMA_REQ[i])
			else $error("dma request while fifo interrupt enabled");
		// request follows the enabled trigger one cycle later
		dma_follow_a: assert property (@(posedge SYS_CLK) disable iff (RST)
			trig_r[TRIG_DMA_LSB + i] && !irqen_r[IRQ_FIFO_LSB + i] && fifo_cnt[i] <= CNT_W'(fifo_lvl[i])
			|=> DMA_REQ[i])
			else $error("dma request missing for trigger");
		// fifo sources latch into pending while enabled
		fifo_pend_a: assert property (@(posedge SYS_CLK) disable iff (RST)
			irqen_r[IRQ_FIFO_LSB + i] && (fifo_full[i] || fifo_empty[i] || trig_hit[i])
			|=> pend_r[IRQ_FIFO_LSB + i])
			else $error("fifo pending bit not set");
	end

	// converter power sequencing, zero crossings and clipping sources
	assign src[IRQ_PWRUP_LSB +: NUM_CONV] = POWERUP_DONE;
	assign src[IRQ_PWRDN_LSB +: NUM_CONV] = POWERDOWN_DONE;
	assign src[IRQ_ZX_LEFT] = LEFT_FILTER_SIGN ^ sign_l_r;
	assign src[IRQ_ZX_RIGHT] = RIGHT_FILTER_SIGN ^ sign_r_r;
	assign src[IRQ_MIC_CLIP] = MIC_CLIP;
	assign src[IRQ_ST_CLIP] = SIDETONE_CLIP_L | SIDETONE_CLIP_R;
	assign src[REG_W-1:NUM_SRC] = '0;

	// previous filter sign, for sign-change detection
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			sign_l_r <= 1'b0;
			sign_r_r <= 1'b0;
		end else begin
			sign_l_r <= LEFT_FILTER_SIGN;
			sign_r_r <= RIGHT_FILTER_SIGN;
		end
	end

	// trigger control register
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			trig_r <= REG_RST;
		end else if (wr_sel == SEL_TRIG) begin
			trig_r <= cfer_merge(trig_r, rb.wr_data, rb.wr_strb);
		end
	end

	// interrupt enable register, reserved top bits held at zero
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			irqen_r <= REG_RST;
		end else if (wr_sel == SEL_IRQEN) begin
			irqen_r <= cfer_merge(irqen_r, rb.wr_data, rb.wr_strb) & IRQ_USED_MASK;
		end
	end

	// coefficient and filter control registers
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			cout_r <= REG_RST;
			cin_r <= REG_RST;
			filt_r <= REG_RST;
		end else begin
			if (wr_sel == SEL_COUT) begin
				cout_r <= cfer_merge(cout_r, rb.wr_data, rb.wr_strb);
			end
			if (wr_sel == SEL_CIN) begin
				cin_r <= cfer_merge(cin_r, rb.wr_data, rb.wr_strb);
			end
			if (wr_sel == SEL_FILT) begin
				filt_r <= cfer_merge(filt_r, rb.wr_data, rb.wr_strb);
			end
		end
	end

	// write-one-to-clear mask for pending bits
	assign pend_clr = (wr_sel == SEL_PEND) ?
		cfer_merge(REG_RST, rb.wr_data, rb.wr_strb) : REG_RST;

	// pending: a new event beats a clear in the same cycle
	assign pend_nxt = ((pend_r & ~pend_clr) | (src & irqen_r)) & IRQ_USED_MASK;

	// pending register only advances while some enable is set
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			pend_r <= REG_RST;
		end else if (|irqen_r) begin
			pend_r <= pend_nxt;
		end
	end

	// request outputs
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			DMA_REQ <= '0;
			CODEC_IRQ <= 1'b0;
		end else begin
			DMA_REQ <= dma_nxt;
			CODEC_IRQ <= (|irqen_r) ? |pend_nxt : |pend_r;
		end
	end

	// coefficients reach the filter only with custom compensation selected
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			CUSTOM_COMP <= 1'b0;
			COEFF_OUTER <= REG_RST;
			COEFF_INNER <= REG_RST;
		end else begin
			CUSTOM_COMP <= filt_r[FILT_CUSTOM_BIT];
			COEFF_OUTER <= filt_r[FILT_CUSTOM_BIT] ? cout_r : REG_RST;
			COEFF_INNER <= filt_r[FILT_CUSTOM_BIT] ? cin_r : REG_RST;
		end
	end

	// read multiplexer, unmapped offsets read zero
	always_comb begin
		rb.rd_data = '0;
		case (cfer_decode(rb.rd_addr))
			SEL_TRIG: rb.rd_data[REG_W-1:0] = trig_r;
			SEL_IRQEN: rb.rd_data[REG_W-1:0] = irqen_r;
			SEL_PEND: rb.rd_data[REG_W-1:0] = pend_r;
			SEL_COUT: rb.rd_data[REG_W-1:0] = cout_r;
			SEL_CIN: rb.rd_data[REG_W-1:0] = cin_r;
			SEL_FILT: rb.rd_data[REG_W-1:0] = filt_r;
			default: rb.rd_data = '0;
		endcase
	end

	// checks on registers and requests
	trig_rst_a: assert property (@(posedge SYS_CLK) RST |=> trig_r == REG_RST && irqen_r == REG_RST)
		else $error("control registers not zero after reset");

	pend_gate_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		irqen_r == REG_RST |=> $stable(pend_r))
		else $error("pending changed with all enables clear");

	pend_only_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		$rose(pend_r[IRQ_MIC_CLIP]) |-> $past(irqen_r[IRQ_MIC_CLIP]) && $past(MIC_CLIP))
		else $error("pending set without enabled source");

	pwrup_pend_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		irqen_r[IRQ_PWRUP_LSB] && POWERUP_DONE[0] |=> pend_r[IRQ_PWRUP_LSB])
		else $error("power-up pending missing");

	pwrdn_pend_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		irqen_r[IRQ_PWRDN_LSB + 2] && POWERDOWN_DONE[2] |=> pend_r[IRQ_PWRDN_LSB + 2])
		else $error("power-down pending missing");

	zero_cross_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(irqen_r[IRQ_ZX_LEFT] && $changed(LEFT_FILTER_SIGN) |=> pend_r[IRQ_ZX_LEFT])
		and (irqen_r[IRQ_ZX_RIGHT] && $changed(RIGHT_FILTER_SIGN) |=> pend_r[IRQ_ZX_RIGHT]))
		else $error("zero crossing not latched");

	st_clip_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		irqen_r[IRQ_ST_CLIP] && SIDETONE_CLIP_R |=> pend_r[IRQ_ST_CLIP])
		else $error("sidetone clip pending missing");

	pend_clr_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(|irqen_r) && pend_clr[IRQ_MIC_CLIP] && !(src[IRQ_MIC_CLIP] && irqen_r[IRQ_MIC_CLIP])
		|=> !pend_r[IRQ_MIC_CLIP])
		else $error("write-one did not clear pending");

	irq_out_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		##1 CODEC_IRQ == (|pend_r))
		else $error("interrupt output disagrees with pending");

	rsvd_zero_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		irqen_r[REG_W-1:NUM_SRC] == '0 && pend_r[REG_W-1:NUM_SRC] == '0)
		else $error("reserved enable bits not zero");

	coeff_gate_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		!filt_r[FILT_CUSTOM_BIT] |=> COEFF_OUTER == REG_RST && COEFF_INNER == REG_RST)
		else $error("coefficients applied without custom compensation");

	// main scenarios
	irq_raise_c: cover property (@(posedge SYS_CLK) disable iff (RST) $rose(CODEC_IRQ));
	dma_raise_c: cover property (@(posedge SYS_CLK) disable iff (RST) $rose(DMA_REQ[0]));
	clr_race_c: cover property (@(posedge SYS_CLK) disable iff (RST)
		|(pend_clr & src & irqen_r));
	bus_err_c: cover property (@(posedge SYS_CLK) disable iff (RST)
		S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
endmodule : cfer_event_req

// file: cfer_pkg.sv
// package: register map, field layout and decode for the codec event request block
package cfer_pkg;
	// bus widths
	localparam int AXI_ADDR_W = 8;
	localparam int AXI_DATA_W = 32;
	localparam int AXI_STRB_W = 4;
	localparam int REG_W = 16;
	// register byte offsets
	localparam logic [AXI_ADDR_W-1:0] OFS_TRIG_CTRL = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h04;
	localparam logic [AXI_ADDR_W-1:0] OFS_IRQ_PENDING = 8'h08;
	localparam logic [AXI_ADDR_W-1:0] OFS_COEFF_OUTER = 8'h0c;
	localparam logic [AXI_ADDR_W-1:0] OFS_COEFF_INNER = 8'h10;
	localparam logic [AXI_ADDR_W-1:0] OFS_FILTER_CTRL = 8'h14;
	// reset values
	localparam logic [REG_W-1:0] REG_RST = 16'h0000;
	// trigger control fields
	localparam int TRIG_LVL_W = 4;
	localparam int TRIG_CAP1_LSB = 0;
	localparam int TRIG_CAP2_LSB = 4;
	localparam int TRIG_PLAY_LSB = 8;
	localparam int TRIG_DMA_LSB = 12;
	// interrupt enable / pending bit positions
	localparam int NUM_FIFO = 4;
	localparam int NUM_CONV = 3;
	localparam int NUM_SRC = 14;
	localparam int IRQ_FIFO_LSB = 0;
	localparam int IRQ_PWRUP_LSB = 4;
	localparam int IRQ_PWRDN_LSB = 7;
	localparam int IRQ_ZX_LEFT = 10;
	localparam int IRQ_ZX_RIGHT = 11;
	localparam int IRQ_MIC_CLIP = 12;
	localparam int IRQ_ST_CLIP = 13;
	localparam logic [REG_W-1:0] IRQ_USED_MASK = 16'h3fff;
	// filter control fields
	localparam int FILT_CUSTOM_BIT = 0;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// register selection
	typedef enum {SEL_TRIG, SEL_IRQEN, SEL_PEND, SEL_COUT, SEL_CIN, SEL_FILT, SEL_NONE} cfer_sel_e;
	// address decode, shared by bus slave and register file
	function automatic cfer_sel_e cfer_decode(input logic [AXI_ADDR_W-1:0] addr);
		case (addr)
			OFS_TRIG_CTRL: cfer_decode = SEL_TRIG;
			OFS_IRQ_ENABLE: cfer_decode = SEL_IRQEN;
			OFS_IRQ_PENDING: cfer_decode = SEL_PEND;
			OFS_COEFF_OUTER: cfer_decode = SEL_COUT;
			OFS_COEFF_INNER: cfer_decode = SEL_CIN;
			OFS_FILTER_CTRL: cfer_decode = SEL_FILT;
			default: cfer_decode = SEL_NONE;
		endcase
	endfunction : cfer_decode
endpackage : cfer_pkg

// file: cfer_reg_if.sv
// interface: register access between bus slave and register file
`timescale 1ns/1ns
interface cfer_reg_if import cfer_pkg::*; ();
	logic wr_stb;
	logic [AXI_ADDR_W-1:0] wr_addr;
	logic [AXI_DATA_W-1:0] wr_data;
	logic [AXI_STRB_W-1:0] wr_strb;
	logic [AXI_ADDR_W-1:0] rd_addr;
	logic [AXI_DATA_W-1:0] rd_data;
	modport master (output wr_stb, wr_addr, wr_data, wr_strb, rd_addr, input rd_data);
	modport target (input wr_stb, wr_addr, wr_data, wr_strb, rd_addr, output rd_data);
endinterface : cfer_reg_if

// file: cfer_axil_slave.sv
// module: axi4-lite slave front end for the codec event request registers
`timescale 1ns/1ns
module cfer_axil_slave import cfer_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// write address and data
	input wire logic [AXI_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [AXI_DATA_W-1:0] wdata,
	input wire logic [AXI_STRB_W-1:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read address and data
	input wire logic [AXI_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [AXI_DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// register side
	cfer_reg_if.master rb
);
	typedef enum {RD_IDLE, RD_FETCH, RD_RESP} cfer_rd_e;
	logic aw_held_r;
	logic w_held_r;
	logic [AXI_ADDR_W-1:0] awaddr_r;
	logic [AXI_ADDR_W-1:0] araddr_r;
	logic [AXI_DATA_W-1:0] wdata_r;
	logic [AXI_STRB_W-1:0] wstrb_r;
	cfer_rd_e rd_state_r;

	// write strobe once both halves are held and no response is out
	assign rb.wr_stb = aw_held_r & w_held_r & ~bvalid;
	assign rb.wr_addr = awaddr_r;
	assign rb.wr_data = wdata_r;
	assign rb.wr_strb = wstrb_r;
	assign rb.rd_addr = araddr_r;

	// write address channel, blocked until the response is taken
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_held_r <= 1'b0;
			awready <= 1'b0;
			awaddr_r <= '0;
		end else if (awvalid && awready) begin
			aw_held_r <= 1'b1;
			awready <= 1'b0;
			awaddr_r <= awaddr;
		end else if (bvalid && bready) begin
			aw_held_r <= 1'b0;
			awready <= 1'b1;
		end else begin
			awready <= ~aw_held_r;
		end
	end

	// write data channel, independent of the address
	always_ff @(posedge clk) begin
		if (rst) begin
			w_held_r <= 1'b0;
			wready <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else if (wvalid && wready) begin
			w_held_r <= 1'b1;
			wready <= 1'b0;
			wdata_r <= wdata;
			wstrb_r <= wstrb;
		end else if (bvalid && bready) begin
			w_held_r <= 1'b0;
			wready <= 1'b1;
		end else begin
			wready <= ~w_held_r;
		end
	end

	// write response, error for unmapped offsets
	always_ff @(posedge clk) begin
		if (rst) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (rb.wr_stb) begin
			bvalid <= 1'b1;
			bresp <= (cfer_decode(awaddr_r) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// read path: take address, fetch one cycle, hold data until taken
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_state_r <= RD_IDLE;
			arready <= 1'b0;
			araddr_r <= '0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else begin
			case (rd_state_r)
				RD_IDLE: begin
					arready <= 1'b1;
					if (arvalid && arready) begin
						araddr_r <= araddr;
						arready <= 1'b0;
						rd_state_r <= RD_FETCH;
					end
				end
				RD_FETCH: begin
					rdata <= rb.rd_data;
					rresp <= (cfer_decode(araddr_r) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
					rvalid <= 1'b1;
					rd_state_r <= RD_RESP;
				end
				RD_RESP: begin
					if (rready) begin
						rvalid <= 1'b0;
						rd_state_r <= RD_IDLE;
					end
				end
				default: rd_state_r <= RD_IDLE;
			endcase
		end
	end
endmodule : cfer_axil_slave

// file: cfer_dma_model.sv
// model: dma controller servicing the codec fifo requests
`timescale 1ns/1ns
module cfer_dma_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// requests from the codec
	input wire logic [3:0] req,
	// request cycles served, one byte per channel
	output logic [31:0] served
);
	// one transfer per cycle that a request stands
	always_ff @(posedge clk) begin
		if (rst) begin
			served <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (req[i]) served[8*i +: 8] <= served[8*i +: 8] + 8'h01;
			end
		end
	end
endmodule : cfer_dma_model

// file: cfer_event_req_tb_top.sv
// testbench: registers, dma requests and interrupt pending of the event block
`timescale 1ns/1ns
module cfer_event_req_tb_top import cfer_pkg::*;;
	logic clk;
	logic rst = 1'b1;
	logic [7:0] awaddr = '0;
	logic [7:0] araddr = '0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hf;
	logic [4:0] cnt [4] = '{default: 5'h1f};
	logic [13:0] ev = '0;
	logic [3:0] emp = '0;
	logic st_r = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, cust;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, served;
	logic [3:0] dma;
	logic [15:0] cout, cin;
	int failures = 0;
	int n_compared = 0;
	int cyc = 0;
	// clock, 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// device under test
	cfer_event_req i_dut (.SYS_CLK(clk), .RST(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.CAP1_EMPTY_WORDS(cnt[0]), .CAP1_FULL(ev[0]), .CAP1_EMPTY(emp[0]),
		.CAP2_EMPTY_WORDS(cnt[1]), .CAP2_FULL(ev[1]), .CAP2_EMPTY(emp[1]),
		.PLAY_L_VALID_WORDS(cnt[2]), .PLAY_L_FULL(ev[2]), .PLAY_L_EMPTY(emp[2]),
		.PLAY_R_VALID_WORDS(cnt[3]), .PLAY_R_FULL(ev[3]), .PLAY_R_EMPTY(emp[3]),
		.POWERUP_DONE(ev[6:4]), .POWERDOWN_DONE(ev[9:7]),
		.LEFT_FILTER_SIGN(ev[10]), .RIGHT_FILTER_SIGN(ev[11]), .MIC_CLIP(ev[12]),
		.SIDETONE_CLIP_L(ev[13]), .SIDETONE_CLIP_R(st_r), .DMA_REQ(dma),
		.CODEC_IRQ(irq), .CUSTOM_COMP(cust), .COEFF_OUTER(cout), .COEFF_INNER(cin));
	// far side dma controller
	cfer_dma_model i_dma (.clk(clk), .rst(rst), .req(dma), .served(served));
	// verdict and end of run
	task automatic end_sim();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// bus write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic wrc(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk("write response", {30'h0, RESP_OKAY}, {30'h0, r});
	endtask : wrc
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk("read response", {30'h0, RESP_OKAY}, {30'h0, r});
		chk("read data", e, d);
	endtask : rdc
	// reset values and unmapped place
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		rdc(OFS_TRIG_CTRL, 32'h0);
		rdc(OFS_IRQ_ENABLE, 32'h0);
		rdc(OFS_COEFF_OUTER, 32'h0);
		rdc(OFS_COEFF_INNER, 32'h0);
		chk("requests idle", 32'h0, {27'h0, irq, dma});
		rd(8'h18, d, r);
		chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
		chk("unmapped data", 32'h0, d);
		wr(8'h18, 32'hffff, r);
		chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
	endtask : t_reset
	// register access and coefficient gating
	task automatic t_regs();
		wrc(OFS_TRIG_CTRL, 32'hffff_a5c3);
		rdc(OFS_TRIG_CTRL, 32'h0000_a5c3);
		wrc(OFS_TRIG_CTRL, 32'h0);
		wrc(OFS_IRQ_ENABLE, 32'hffff);
		rdc(OFS_IRQ_ENABLE, 32'h3fff);
		wrc(OFS_IRQ_ENABLE, 32'h0);
		wrc(OFS_COEFF_OUTER, 32'h1234);
		wrc(OFS_COEFF_INNER, 32'h5678);
		repeat (2) @(posedge clk);
		chk("coefficients unused", 32'h0, {cout, cin});
		wrc(OFS_FILTER_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		chk("coefficients used", 32'h1234_5678, {cout, cin});
		chk("custom select", 32'h1, {31'h0, cust});
		wstrb <= 4'h1;
		wrc(OFS_COEFF_INNER, 32'hffff);
		wstrb <= 4'hf;
		rdc(OFS_COEFF_INNER, 32'h56ff);
	endtask : t_regs
	// trigger levels, dma enables and interrupt precedence
	task automatic t_dma();
		wrc(OFS_TRIG_CTRL, 32'hf432);
		cnt <= '{5'h02, 5'h04, 5'h04, 5'h05};
		repeat (3) @(posedge clk);
		chk("dma at levels", 32'h5, {28'h0, dma});
		chk("dma served", 32'h0, {24'h0, served[15:8]});
		cnt <= '{5'h02, 5'h03, 5'h04, 5'h04};
		repeat (3) @(posedge clk);
		chk("dma all", 32'hf, {28'h0, dma});
		wrc(OFS_IRQ_ENABLE, 32'h5);
		repeat (2) @(posedge clk);
		chk("dma overridden", 32'ha, {28'h0, dma});
		rdc(OFS_IRQ_PENDING, 32'h5);
		chk("irq out", 32'h1, {31'h0, irq});
		cnt <= '{default: 5'h1f};
		repeat (2) @(posedge clk);
		wrc(OFS_IRQ_PENDING, 32'h5);
		rdc(OFS_IRQ_PENDING, 32'h0);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wrc(OFS_IRQ_ENABLE, 32'h0);
		wrc(OFS_TRIG_CTRL, 32'h0);
	endtask : t_dma
	// every source alone: full flags, events, then empty flags
	task automatic t_src();
		int k;
		for (int b = 0; b < 18; b++) begin
			k = (b < 14) ? b : b - 14;
			wrc(OFS_IRQ_ENABLE, 32'h1 << k);
			@(posedge clk);
			if (b < 14) ev[k] <= 1'b1;
			else emp[k] <= 1'b1;
			repeat (2) @(posedge clk);
			ev <= '0;
			emp <= '0;
			repeat (3) @(posedge clk);
			rdc(OFS_IRQ_PENDING, 32'h1 << k);
			chk("irq source", 32'h1, {31'h0, irq});
			wrc(OFS_IRQ_PENDING, 32'h1 << k);
			rdc(OFS_IRQ_PENDING, 32'h0);
		end
	endtask : t_src
	// pending held still while disabled or enabled elsewhere
	task automatic t_frz();
		wrc(OFS_IRQ_ENABLE, 32'h0);
		st_r <= 1'b1;
		repeat (2) @(posedge clk);
		st_r <= 1'b0;
		wrc(OFS_IRQ_ENABLE, 32'h1000);
		rdc(OFS_IRQ_PENDING, 32'h0);
		st_r <= 1'b1;
		repeat (3) @(posedge clk);
		st_r <= 1'b0;
		rdc(OFS_IRQ_PENDING, 32'h0);
		wrc(OFS_IRQ_ENABLE, 32'h2000);
		st_r <= 1'b1;
		repeat (3) @(posedge clk);
		st_r <= 1'b0;
		rdc(OFS_IRQ_PENDING, 32'h2000);
		wrc(OFS_IRQ_ENABLE, 32'h0);
		wrc(OFS_IRQ_PENDING, 32'h2000);
		rdc(OFS_IRQ_PENDING, 32'h2000);
		chk("irq held", 32'h1, {31'h0, irq});
	endtask : t_frz
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_dma();
		t_src();
		t_frz();
		end_sim();
	end
endmodule : cfer_event_req_tb_top
